/* ebppc_pkg.sv */
// ebppc_pkg: constants, types and decode functions of the eight-bit port.
// assumes one 50 MHz clock domain; the pads resolve level and enables outside.
package ebppc_pkg;

    localparam int NPIN = 8;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // register indices as printed; byte address is four times the index
    localparam logic [15:0] IDX_LEVEL = 16'hf2de;
    localparam logic [15:0] IDX_DIR = 16'hf2df;
    localparam logic [15:0] IDX_DRV_LO = 16'hf2e0;
    localparam logic [15:0] IDX_DRV_HI = 16'hf2e1;
    localparam logic [15:0] IDX_FN_LO = 16'hf2e2;
    localparam logic [15:0] IDX_FN_HI = 16'hf2e3;

    // register select codes
    localparam logic [2:0] SEL_LEVEL = 3'h0;
    localparam logic [2:0] SEL_DIR = 3'h1;
    localparam logic [2:0] SEL_DRV_LO = 3'h2;
    localparam logic [2:0] SEL_DRV_HI = 3'h3;
    localparam logic [2:0] SEL_FN_LO = 3'h4;
    localparam logic [2:0] SEL_FN_HI = 3'h5;
    localparam logic [2:0] SEL_NONE = 3'h7;
    localparam int NREG = 6;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    localparam logic [23:0] RDATA_PAD = 24'h00_0000;
    localparam logic HRESP_OKAY = 1'b0;
    localparam int HTRANS_ACTIVE_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////////////////////
    localparam logic DIR_OUT = 1'b0;
    localparam logic [1:0] DRV_HIZ = 2'h0;
    localparam logic [1:0] DRV_PCH = 2'h1;
    localparam logic [1:0] DRV_NCH = 2'h2;
    localparam logic [1:0] DRV_PP = 2'h3;
    localparam logic [1:0] IN_PULL_DOWN = 2'h1;
    localparam logic [1:0] IN_PULL_UP = 2'h2;

    typedef enum logic [1:0] {
        FN_PORT = 2'b00,
        FN_ALT1 = 2'b01,
        FN_ALT2 = 2'b10,
        FN_RSVD = 2'b11
    } ebppc_fn_t;

    // pins whose code 01 is reserved
    localparam logic [7:0] ALT1_RSVD_MASK = 8'h0c;

    localparam int PIN_SDA = 0;
    localparam int PIN_SCL = 1;
    localparam int PIN_P2 = 2;
    localparam int PIN_P3 = 3;
    localparam int PIN_RX1 = 4;
    localparam int PIN_TX1 = 5;
    localparam int PIN_RX0 = 6;
    localparam int PIN_TX0 = 7;

    ////////////////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic async0_transmit;
        logic async1_transmit;
        logic sync_serial_data_out;
        logic sync_serial_clock;
        logic pulse_width_out_a;
        logic pulse_width_out_b;
        logic scl_out;
        logic sda_out;
    } ebppc_periph_out_t;

    typedef struct packed {
        logic async0_receive;
        logic async1_receive;
        logic sync_serial_data_in;
        logic sync_serial_clock;
        logic scl_in;
        logic sda_in;
    } ebppc_periph_in_t;

    localparam ebppc_periph_in_t PERIPH_IN_IDLE = 6'h33;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe_n;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
    } ebppc_pad_t;

    localparam ebppc_pad_t PAD_RESET = 32'h00ff_0000;

    ////////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] reg_decode(input logic [31:0] addr);
        logic [2:0] sel;
        sel = SEL_NONE;
        if (addr == {14'h0000, IDX_LEVEL, 2'b00}) sel = SEL_LEVEL;
        if (addr == {14'h0000, IDX_DIR, 2'b00}) sel = SEL_DIR;
        if (addr == {14'h0000, IDX_DRV_LO, 2'b00}) sel = SEL_DRV_LO;
        if (addr == {14'h0000, IDX_DRV_HI, 2'b00}) sel = SEL_DRV_HI;
        if (addr == {14'h0000, IDX_FN_LO, 2'b00}) sel = SEL_FN_LO;
        if (addr == {14'h0000, IDX_FN_HI, 2'b00}) sel = SEL_FN_HI;
        return sel;
    endfunction

    // returns {level, oe_n}; oe_n low means the pad drives
    function automatic logic [1:0] pin_drive(input logic dir, input logic [1:0] code,
                                             input logic v);
        logic [1:0] r;
        r = 2'b01;
        if (dir == DIR_OUT) begin
            case (code)
                DRV_PCH: r = {v, ~v};
                DRV_NCH: r = {1'b0, v};
                DRV_PP: r = {v, 1'b0};
                default: r = 2'b01;
            endcase
        end
        return r;
    endfunction

endpackage

/* ebppc_sync.sv */
// ebppc_sync: two-stage synchroniser for the pad input levels.
// assumes inputs asynchronous to hclk; only the second stage is read.
`timescale 1ns/100ps
module ebppc_sync #(
    parameter int W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] stage1_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1_reg <= '0;
            sync_out <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end

endmodule

/* ebppc_top.sv */
// ebppc_top: eight-bit port pin control with an AHB-Lite register slave.
// assumes a single AHB-Lite master, zero-wait slave, pads outside resolve the wire.
// How it works
// - per-pin direction bit, 0 output, 1 input
// - output drive code: hiz, pch, nch, push-pull
// - input code: hiz, pull-down, pull-up, hiz
// - reset gives output direction, high impedance
// - output pin follows stored data bit
// - input pins read back sampled level
// - pin 7: port, async0 tx, pulse a
// - pin 6: port, async0 rx, sync data out
// - pin 5: port, async1 tx, sync clock
// - pin 4: port, async1 rx, sync data in
// - pin 3: port or pulse b
// - pin 2: port or sync data out
// - pin 1: port, i2c clock, sync clock
// - pin 0: port, i2c data, sync data in
// - reserved code: data ignored, output value low; pin floats under hiz or pch drive, driven low under nch or push-pull
// - output pins read stored value, reset zero
`timescale 1ns/100ps
module ebppc_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] pin_in,
    output ebppc_pkg::ebppc_pad_t pad,
    input wire ebppc_pkg::ebppc_periph_out_t periph_out,
    output ebppc_pkg::ebppc_periph_in_t periph_in
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // bus slave: writes land in the data phase, reads are registered at the address phase
    logic [7:0] regs_reg [ebppc_pkg::NREG];
    logic [7:0] regs_next [ebppc_pkg::NREG];
    logic wr_pend_reg;
    logic [2:0] wr_sel_reg;
    logic [7:0] sampled;

    wire addr_phase = hsel & htrans[ebppc_pkg::HTRANS_ACTIVE_BIT] & hready;
    wire [2:0] ap_sel = ebppc_pkg::reg_decode(haddr);
    wire rd_take = addr_phase & ~hwrite;

    // hsize is not checked: only whole-word transfers are issued
    always_comb begin
        for (int i = 0; i < ebppc_pkg::NREG; i++) begin
            regs_next[i] = regs_reg[i];
            if (wr_pend_reg && wr_sel_reg == 3'(i)) begin
                regs_next[i] = hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < ebppc_pkg::NREG; i++) begin
                regs_reg[i] <= ebppc_pkg::REG_RESET;
            end
        end else begin
            for (int i = 0; i < ebppc_pkg::NREG; i++) begin
                regs_reg[i] <= regs_next[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_sel_reg <= ebppc_pkg::SEL_NONE;
        end else begin
            wr_pend_reg <= addr_phase & hwrite;
            wr_sel_reg <= ap_sel;
        end
    end

    // read path sees a write still in its data phase, so back-to-back is coherent
    wire [7:0] level_fwd = regs_next[ebppc_pkg::SEL_LEVEL];
    wire [7:0] dir_fwd = regs_next[ebppc_pkg::SEL_DIR];
    wire [7:0] level_read = (dir_fwd & sampled) | (~dir_fwd & level_fwd);
    wire [7:0] rd_val = (ap_sel == ebppc_pkg::SEL_LEVEL) ? level_read :
                        (ap_sel == ebppc_pkg::SEL_NONE) ? ebppc_pkg::REG_RESET :
                        regs_next[ap_sel];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= ebppc_pkg::RDATA_ZERO;
            hreadyout <= 1'b1;
            hresp <= ebppc_pkg::HRESP_OKAY;
        end else begin
            hrdata <= rd_take ? {ebppc_pkg::RDATA_PAD, rd_val} : ebppc_pkg::RDATA_ZERO;
            hreadyout <= 1'b1;
            hresp <= ebppc_pkg::HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // coined register names
    wire [7:0] pin_level_register = regs_reg[ebppc_pkg::SEL_LEVEL];
    wire [7:0] pin_direction_register = regs_reg[ebppc_pkg::SEL_DIR];
    wire [7:0] pin_drive_type_lo = regs_reg[ebppc_pkg::SEL_DRV_LO];
    wire [7:0] pin_drive_type_hi = regs_reg[ebppc_pkg::SEL_DRV_HI];
    wire [7:0] pin_function_select_lo = regs_reg[ebppc_pkg::SEL_FN_LO];
    wire [7:0] pin_function_select_hi = regs_reg[ebppc_pkg::SEL_FN_HI];

    ebppc_sync #(
        .W(ebppc_pkg::NPIN)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(pin_in),
        .sync_out(sampled)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // per-pin function codes and the peripheral values behind them
    ebppc_pkg::ebppc_fn_t fn [ebppc_pkg::NPIN];
    wire [7:0] alt1;
    wire [7:0] alt2;
    logic [7:0] out_val;
    ebppc_pkg::ebppc_pad_t pad_next;

    always_comb begin
        for (int i = 0; i < ebppc_pkg::NPIN; i++) begin
            fn[i] = ebppc_pkg::ebppc_fn_t'({pin_function_select_hi[i], pin_function_select_lo[i]});
        end
    end

    // input-only functions keep the stored data as their output value
    assign alt1[ebppc_pkg::PIN_TX0] = periph_out.async0_transmit;
    assign alt2[ebppc_pkg::PIN_TX0] = periph_out.pulse_width_out_a;
    assign alt1[ebppc_pkg::PIN_RX0] = pin_level_register[ebppc_pkg::PIN_RX0];
    assign alt2[ebppc_pkg::PIN_RX0] = periph_out.sync_serial_data_out;
    assign alt1[ebppc_pkg::PIN_TX1] = periph_out.async1_transmit;
    assign alt2[ebppc_pkg::PIN_TX1] = periph_out.sync_serial_clock;
    assign alt1[ebppc_pkg::PIN_RX1] = pin_level_register[ebppc_pkg::PIN_RX1];
    assign alt2[ebppc_pkg::PIN_RX1] = pin_level_register[ebppc_pkg::PIN_RX1];
    assign alt1[ebppc_pkg::PIN_P3] = 1'b0;
    assign alt2[ebppc_pkg::PIN_P3] = periph_out.pulse_width_out_b;
    assign alt1[ebppc_pkg::PIN_P2] = 1'b0;
    assign alt2[ebppc_pkg::PIN_P2] = periph_out.sync_serial_data_out;
    assign alt1[ebppc_pkg::PIN_SCL] = periph_out.scl_out;
    assign alt2[ebppc_pkg::PIN_SCL] = periph_out.sync_serial_clock;
    assign alt1[ebppc_pkg::PIN_SDA] = periph_out.sda_out;
    assign alt2[ebppc_pkg::PIN_SDA] = pin_level_register[ebppc_pkg::PIN_SDA];

    // reserved codes force a zero value; the drive decode then floats or pulls low
    wire [7:0] rsvd_mask;
    for (genvar g = 0; g < ebppc_pkg::NPIN; g++) begin : g_pin
        assign rsvd_mask[g] = (fn[g] == ebppc_pkg::FN_RSVD) |
                              ((fn[g] == ebppc_pkg::FN_ALT1) &
                               ebppc_pkg::ALT1_RSVD_MASK[g]);
    end

    always_comb begin
        for (int i = 0; i < ebppc_pkg::NPIN; i++) begin
            case (fn[i])
                ebppc_pkg::FN_PORT: out_val[i] = pin_level_register[i];
                ebppc_pkg::FN_ALT1: out_val[i] = alt1[i];
                ebppc_pkg::FN_ALT2: out_val[i] = alt2[i];
                default: out_val[i] = 1'b0;
            endcase
            if (rsvd_mask[i]) begin
                out_val[i] = 1'b0;
            end
        end
    end

    wire [7:0] is_input = pin_direction_register;
    wire [7:0] pu_mask = is_input & pin_drive_type_hi & ~pin_drive_type_lo;
    wire [7:0] pd_mask = is_input & ~pin_drive_type_hi & pin_drive_type_lo;

    always_comb begin
        pad_next = ebppc_pkg::PAD_RESET;
        for (int i = 0; i < ebppc_pkg::NPIN; i++) begin
            {pad_next.level[i], pad_next.oe_n[i]} = ebppc_pkg::pin_drive(
                is_input[i], {pin_drive_type_hi[i], pin_drive_type_lo[i]}, out_val[i]);
        end
        pad_next.pull_up = pu_mask;
        pad_next.pull_down = pd_mask;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // peripheral inputs: idle level when the function is not selected
    ebppc_pkg::ebppc_periph_in_t pin_next;

    always_comb begin
        pin_next = ebppc_pkg::PERIPH_IN_IDLE;
        if (fn[ebppc_pkg::PIN_RX0] == ebppc_pkg::FN_ALT1) begin
            pin_next.async0_receive = sampled[ebppc_pkg::PIN_RX0];
        end
        if (fn[ebppc_pkg::PIN_RX1] == ebppc_pkg::FN_ALT1) begin
            pin_next.async1_receive = sampled[ebppc_pkg::PIN_RX1];
        end
        if (fn[ebppc_pkg::PIN_RX1] == ebppc_pkg::FN_ALT2) begin
            pin_next.sync_serial_data_in = sampled[ebppc_pkg::PIN_RX1];
        end else if (fn[ebppc_pkg::PIN_SDA] == ebppc_pkg::FN_ALT2) begin
            pin_next.sync_serial_data_in = sampled[ebppc_pkg::PIN_SDA];
        end
        if (fn[ebppc_pkg::PIN_TX1] == ebppc_pkg::FN_ALT2) begin
            pin_next.sync_serial_clock = sampled[ebppc_pkg::PIN_TX1];
        end else if (fn[ebppc_pkg::PIN_SCL] == ebppc_pkg::FN_ALT2) begin
            pin_next.sync_serial_clock = sampled[ebppc_pkg::PIN_SCL];
        end
        if (fn[ebppc_pkg::PIN_SCL] == ebppc_pkg::FN_ALT1) begin
            pin_next.scl_in = sampled[ebppc_pkg::PIN_SCL];
        end
        if (fn[ebppc_pkg::PIN_SDA] == ebppc_pkg::FN_ALT1) begin
            pin_next.sda_in = sampled[ebppc_pkg::PIN_SDA];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad <= ebppc_pkg::PAD_RESET;
            periph_in <= ebppc_pkg::PERIPH_IN_IDLE;
        end else begin
            pad <= pad_next;
            periph_in <= pin_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wire [7:0] out_dir = ~is_input;
    wire [7:0] hiz_mask = out_dir & ~pin_drive_type_hi & ~pin_drive_type_lo;
    wire [7:0] pp_port_mask = out_dir & pin_drive_type_hi & pin_drive_type_lo & ~rsvd_mask &
                              ~pin_function_select_hi & ~pin_function_select_lo;
    wire [7:0] rsvd_low_mask = out_dir & pin_drive_type_hi & rsvd_mask;
    wire [7:0] nch_mask = out_dir & pin_drive_type_hi & ~pin_drive_type_lo;

    a_hiz_floats: assert property (
        1'b1 |=> ((pad.oe_n & $past(hiz_mask)) == $past(hiz_mask)))
        else $error("high-impedance output pin is driven");
    a_pp_follows: assert property (
        1'b1 |=> (((pad.level ^ $past(pin_level_register)) & $past(pp_port_mask)) == 8'h00)
                 && ((pad.oe_n & $past(pp_port_mask)) == 8'h00))
        else $error("push-pull port pin does not follow data");
    a_input_floats: assert property (
        1'b1 |=> ((pad.oe_n & $past(is_input)) == $past(is_input)))
        else $error("input pin is driven");
    a_pull_decode: assert property (
        1'b1 |=> (pad.pull_up == $past(pu_mask)) && (pad.pull_down == $past(pd_mask))
                 && ((pad.pull_up & pad.pull_down) == 8'h00))
        else $error("pull selection wrong");
    a_rsvd_low: assert property (
        1'b1 |=> ((pad.level & $past(rsvd_low_mask)) == 8'h00)
                 && ((pad.oe_n & $past(rsvd_low_mask)) == 8'h00))
        else $error("reserved code pin not held low");
    a_read_input: assert property (
        (rd_take && ap_sel == ebppc_pkg::SEL_LEVEL)
        |=> ((hrdata[7:0] & $past(dir_fwd)) == ($past(sampled) & $past(dir_fwd))))
        else $error("input pin read does not give sampled level");
    a_write_store: assert property (
        (addr_phase && hwrite && ap_sel == ebppc_pkg::SEL_LEVEL)
        ##1 1'b1 |=> pin_level_register == $past(hwdata[7:0]))
        else $error("data register write lost");
    a_rx0_route: assert property (
        (fn[ebppc_pkg::PIN_RX0] == ebppc_pkg::FN_ALT1)
        |=> periph_in.async0_receive == $past(sampled[ebppc_pkg::PIN_RX0]))
        else $error("async0 receive not routed");
    a_tx0_route: assert property (
        (fn[ebppc_pkg::PIN_TX0] == ebppc_pkg::FN_ALT1 && out_dir[ebppc_pkg::PIN_TX0] &&
         pin_drive_type_hi[ebppc_pkg::PIN_TX0] && pin_drive_type_lo[ebppc_pkg::PIN_TX0])
        |=> pad.level[ebppc_pkg::PIN_TX0] == $past(periph_out.async0_transmit))
        else $error("async0 transmit not on pin 7");
    a_bus_okay: assert property (
        hreadyout && hresp == ebppc_pkg::HRESP_OKAY &&
        ($past(rd_take) || hrdata == ebppc_pkg::RDATA_ZERO))
        else $error("bus answer not zero-wait okay");
    a_nch_low_only: assert property (
        1'b1 |=> ((pad.level & $past(nch_mask)) == 8'h00))
        else $error("n-channel pin driven high");
    a_read_output: assert property (
        (rd_take && ap_sel == ebppc_pkg::SEL_LEVEL)
        |=> (((hrdata[7:0] ^ $past(level_fwd)) & ~$past(dir_fwd)) == 8'h00))
        else $error("output pin read does not give stored value");
    a_rx1_route: assert property (
        (fn[ebppc_pkg::PIN_RX1] == ebppc_pkg::FN_ALT1)
        |=> periph_in.async1_receive == $past(sampled[ebppc_pkg::PIN_RX1]))
        else $error("async1 receive not routed");
    a_scl_route: assert property (
        (fn[ebppc_pkg::PIN_SCL] == ebppc_pkg::FN_ALT1)
        |=> periph_in.scl_in == $past(sampled[ebppc_pkg::PIN_SCL]))
        else $error("i2c clock not routed");
    a_sda_route: assert property (
        (fn[ebppc_pkg::PIN_SDA] == ebppc_pkg::FN_ALT1)
        |=> periph_in.sda_in == $past(sampled[ebppc_pkg::PIN_SDA]))
        else $error("i2c data not routed");
    a_rx0_idle: assert property (
        (fn[ebppc_pkg::PIN_RX0] != ebppc_pkg::FN_ALT1)
        |=> periph_in.async0_receive == ebppc_pkg::PERIPH_IN_IDLE.async0_receive)
        else $error("async0 receive not idle when unselected");

    c_write: cover property (addr_phase && hwrite ##1 wr_pend_reg);
    c_read_back: cover property (wr_pend_reg ##1 rd_take);
    c_periph: cover property (fn[ebppc_pkg::PIN_SCL] == ebppc_pkg::FN_ALT1 && out_dir[1]);
    c_rsvd: cover property (rsvd_low_mask != 8'h00);

endmodule

/* ebppc_board.sv */
// ebppc_board: board-side model of the eight port pins.
// assumes the pad struct of ebppc_top; board drive yields to an enabled pad.
`timescale 1ns/100ps
module ebppc_board (
    input wire logic hclk,
    input wire ebppc_pkg::ebppc_pad_t pad,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    // a floating pin wanders, so a stale level is never read as valid
    logic [7:0] wander_reg = 8'h00;

    always @(posedge hclk) begin
        wander_reg <= ~wander_reg;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad.oe_n[i]) begin
                pin_in[i] = pad.level[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pad.pull_up[i] | pad.pull_down[i]) begin
                pin_in[i] = pad.pull_up[i];
            end else begin
                pin_in[i] = wander_reg[i];
            end
        end
    end
endmodule

/* tb_eight_bit_port_pin_control.sv */
// tb_eight_bit_port_pin_control: self-checking bench for the eight-bit port.
// assumes ebppc_top as sole AHB-Lite slave and ebppc_board on the pins.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_eight_bit_port_pin_control;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp;
    logic [31:0] hrdata, e_rd;
    logic [7:0] pin_in;
    logic [7:0] ext_en = 8'hff;
    logic [7:0] ext_val = 8'h00;
    ebppc_pkg::ebppc_pad_t pad;
    ebppc_pkg::ebppc_periph_out_t po = 8'h00;
    ebppc_pkg::ebppc_periph_in_t pi;
    // shadow order: level, direction, drive lo, drive hi, function lo, function hi
    logic [7:0] r [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [15:0] ix [6] = '{ebppc_pkg::IDX_LEVEL, ebppc_pkg::IDX_DIR, ebppc_pkg::IDX_DRV_LO,
        ebppc_pkg::IDX_DRV_HI, ebppc_pkg::IDX_FN_LO, ebppc_pkg::IDX_FN_HI};
    int errors = 0;
    int samples_checked = 0;
    int seed = 13;
    logic rd_dp = 1'b0;
    logic pad_go = 1'b0;
    logic [31:0] rd_q [$];
    logic [37:0] pad_q [$];
    logic [37:0] e_pad;

    always #10 hclk = ~hclk;

    ebppc_top i_ebppc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pad(pad),
        .periph_out(po), .periph_in(pi));

    ebppc_board i_ebppc_board (.hclk(hclk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////
    // watcher: read data at the data-phase edge, pins when a note asks for it
    always @(posedge hclk) begin
        if (rd_dp && hreadyout) begin
            e_rd = rd_q.pop_front();
            `CHK({hresp, hrdata}, {ebppc_pkg::HRESP_OKAY, e_rd})
        end
        if (pad_go) begin
            e_pad = pad_q.pop_front();
            `CHK({pad, pi}, e_pad)
        end
        rd_dp <= hsel && htrans[1] && hreadyout && !hwrite;
    end

    task automatic end_sim();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        $display("ERROR %0t: run timed out", $time);
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n <= 100) begin
            n++;
            @(posedge hclk);
        end
        if (n > 100) begin
            errors++;
            $display("ERROR %0t: bus never ready", $time);
            end_sim();
        end
    endtask

    task automatic ahb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {14'h0, idx, 2'b00};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        rd_q.push_back({24'h0, e});
        ahb(1'b0, idx, 32'h0);
    endtask

    // upper bits carry junk on purpose: they must be dropped
    task automatic set_all();
        logic [23:0] u;
        u = 24'($random(seed));
        for (int k = 0; k < 6; k++) ahb(1'b1, ix[k], {u, r[k]});
        rd(ix[5], r[5]);
        repeat (6) @(posedge hclk);
    endtask

    function automatic ebppc_pkg::ebppc_pad_t exp_pad();
        logic [7:0] a1, a2, v, lv, oe, pu, pd;
        logic [1:0] c, cd;
        a1 = {po.async0_transmit, r[0][6], po.async1_transmit, r[0][4], 2'b00, po.scl_out,
            po.sda_out};
        a2 = {po.pulse_width_out_a, po.sync_serial_data_out, po.sync_serial_clock, r[0][4],
            po.pulse_width_out_b, po.sync_serial_data_out, po.sync_serial_clock, r[0][0]};
        for (int i = 0; i < 8; i++) begin
            c = {r[5][i], r[4][i]};
            cd = {r[3][i], r[2][i]};
            v[i] = (c == 2'h0) ? r[0][i] : (c == 2'h1) ? a1[i] : (c == 2'h2) ? a2[i] : 1'b0;
            lv[i] = !r[1][i] & cd[0] & v[i];
            oe[i] = r[1][i] | (cd == 2'h0) | ((cd == 2'h1) & !v[i]) | ((cd == 2'h2) & v[i]);
            pu[i] = r[1][i] & (cd == 2'h2);
            pd[i] = r[1][i] & (cd == 2'h1);
        end
        return {lv, oe, pu, pd};
    endfunction

    // sampled levels routed to the peripherals; the higher pin wins a shared input
    function automatic logic [5:0] exp_pi(input logic [7:0] w);
        logic [5:0] p;
        p = 6'h33;
        if ({r[5][6], r[4][6]} == 2'h1) p[5] = w[6];
        if ({r[5][4], r[4][4]} == 2'h1) p[4] = w[4];
        if ({r[5][0], r[4][0]} == 2'h2) p[3] = w[0];
        if ({r[5][4], r[4][4]} == 2'h2) p[3] = w[4];
        if ({r[5][1], r[4][1]} == 2'h2) p[2] = w[1];
        if ({r[5][5], r[4][5]} == 2'h2) p[2] = w[5];
        if ({r[5][1], r[4][1]} == 2'h1) p[1] = w[1];
        if ({r[5][0], r[4][0]} == 2'h1) p[0] = w[0];
        return p;
    endfunction

    task automatic chk_state();
        ebppc_pkg::ebppc_pad_t p;
        logic [7:0] w;
        p = exp_pad();
        w = (~p.oe_n & p.level) | (p.oe_n & ext_en & ext_val) | (p.oe_n & ~ext_en & p.pull_up);
        pad_q.push_back({p, exp_pi(w)});
        pad_go <= 1'b1;
        @(posedge hclk);
        pad_go <= 1'b0;
        rd(ix[0], (r[1] & w) | (~r[1] & r[0]));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 0; k < 6; k++) rd(ix[k], 8'h00);
        chk_state();
        ahb(1'b1, 16'hf2e4, 32'hffff_ffff);
        rd(16'hf2e4, 8'h00);
        r[1] = 8'hff;
        r[2] = 8'h0f;
        r[3] = 8'hf0;
        ext_en <= 8'h00;
        set_all();
        chk_state();
        ext_en <= 8'hff;
        for (int n = 0; n < 40; n++) begin
            for (int k = 0; k < 6; k++) r[k] = 8'($random(seed));
            po <= 8'($random(seed));
            ext_val <= 8'($random(seed));
            set_all();
            chk_state();
        end
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 0; k < 6; k++) r[k] = 8'h00;
        chk_state();
        end_sim();
    end
endmodule
